/* bench/dts_host.sv */
`timescale 1ns/1ps
module dts_host #(
  parameter logic [6:0] ADDR = 7'h2B
) (
  output logic smb_clk,
  output logic pull_low,
  input wire logic sda
);
  // quarter bit period; a 200 kHz bus keeps the run short, and the design
  // still sees more than thirty of its own clocks in every bus phase
  localparam time Q = 1250ns;
  logic naks;

  // clock runs only inside frames; compensation is never rewritten here
  initial begin
    smb_clk = 1'b1;
    pull_low = 1'b0;
    naks = 1'b0;
  end

  // one bit out; clock low on entry and exit, data moves only while low
  task automatic bit_out(input logic b);
    pull_low = !b;
    #Q smb_clk = 1'b1;
    #(2*Q) smb_clk = 1'b0;
    #Q;
  endtask

  // one bit in, sampled in mid high phase
  task automatic bit_in(output logic b);
    pull_low = 1'b0;
    #Q smb_clk = 1'b1;
    #Q b = sda;
    #Q smb_clk = 1'b0;
    #Q;
  endtask

  // start and repeated start share one shape
  task automatic start();
    pull_low = 1'b0;
    #Q smb_clk = 1'b1;
    #Q pull_low = 1'b1;
    #Q smb_clk = 1'b0;
    #Q;
  endtask

  task automatic stop();
    pull_low = 1'b1;
    #Q smb_clk = 1'b1;
    #Q pull_low = 1'b0;
    #Q;
  endtask

  // any missing acknowledge is remembered in naks
  task automatic byte_out(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(v[i]);
    bit_in(a);
    naks = naks | a;
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    naks = 1'b0;
    start();
    byte_out({ADDR, 1'b0});
    byte_out(p);
    byte_out(d);
    stop();
  endtask

  // pointer write and repeated start only when asked; last byte is nacked
  task automatic rd(input logic up, input logic [7:0] p, output logic [7:0] d);
    naks = 1'b0;
    if (up) begin
      start();
      byte_out({ADDR, 1'b0});
      byte_out(p);
    end
    start();
    byte_out({ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(1'b1);
    stop();
  endtask

  task automatic probe(input logic [6:0] a);
    naks = 1'b0;
    start();
    byte_out({a, 1'b0});
    stop();
  endtask

  // address byte, then clock parked low far past the bus timeout
  task automatic stall(output logic ack_lvl, output logic end_lvl);
    logic [7:0] v;
    v = {ADDR, 1'b0};
    start();
    for (int i = 7; i >= 0; i--) bit_out(v[i]);
    pull_low = 1'b0;
    #Q ack_lvl = sda;
    #(160*Q) end_lvl = sda;
    stop();
  endtask
endmodule

/* bench/dts_top_asserts.sv */
`timescale 1ns/1ps
module dts_top_chk #(
  parameter int unsigned TIMEOUT_CYCLES = 750000,
  parameter int unsigned ZONE_CYCLES = 562500
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic smb_clk,
  input wire logic smb_sda_in,
  input wire logic smb_sda_o,
  input wire logic smb_sda_oe,
  input wire logic afe_run_r,
  input wire logic [1:0] afe_zone_r,
  input wire logic [1:0] afe_model_r,
  input wire logic [1:0] afe_comp_r,
  input wire logic [1:0] afe_filter_r
);
  logic [31:0] low_cnt_r;
  logic [31:0] zone_cnt_r;
  logic [1:0] zone_last_r;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // cycles with either bus line low, seen on the raw pins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_cnt_r <= 32'h0;
    end else begin
      low_cnt_r <= (smb_clk && smb_sda_in) ? 32'h0 : low_cnt_r + 32'h1;
    end
  end

  // age of the current zone; cleared on a zone change or outside a pass
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      zone_last_r <= 2'h0;
      zone_cnt_r <= 32'h0;
    end else begin
      zone_last_r <= afe_zone_r;
      zone_cnt_r <= (!afe_run_r || afe_zone_r != zone_last_r) ? 32'h0 : zone_cnt_r + 32'h1;
    end
  end

  // slack of 8 covers the two-stage sync ahead of the design's counter
  chk_sda_open_drain: assert property (smb_sda_o == 1'b0)
    else $error("data pin driven high");
  chk_oe_clk_low: assert property ($changed(smb_sda_oe) |-> !smb_clk)
    else $error("data drive changed while clock high");
  chk_bus_timeout: assert property (low_cnt_r > TIMEOUT_CYCLES + 8 |-> !smb_sda_oe)
    else $error("data still driven after long low bus");
  chk_zone_length: assert property (zone_cnt_r <= ZONE_CYCLES)
    else $error("zone conversion too long");
  chk_zone_order: assert property (
    afe_run_r && $past(afe_run_r) && $changed(afe_zone_r)
    |-> afe_zone_r == (($past(afe_zone_r) == 2'h2) ? 2'h0 : $past(afe_zone_r) + 2'h1))
    else $error("zone order broken");
  chk_pass_start: assert property ($rose(afe_run_r) |-> afe_zone_r == 2'h0)
    else $error("pass did not begin with local zone");
  chk_reset_setup: assert property (
    $fell(rst) |-> afe_model_r == 2'h1 && afe_comp_r == 2'h1 && afe_filter_r == 2'h3)
    else $error("front end settings wrong after reset");
  chk_cfg_on_ack: assert property (
    $changed({afe_model_r, afe_comp_r, afe_filter_r}) |-> smb_sda_oe)
    else $error("front end settings changed outside a write");
endmodule

bind dts_top dts_top_chk #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
  .ZONE_CYCLES(ZONE_CYCLES)
) dts_top_chk_i (
  .sys_clk, .rst, .smb_clk, .smb_sda_in, .smb_sda_o, .smb_sda_oe,
  .afe_run_r, .afe_zone_r, .afe_model_r, .afe_comp_r, .afe_filter_r
);

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
  localparam logic [6:0] SA = 7'h2B;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic smb_clk;
  logic pull_low;
  logic smb_sda_o;
  logic smb_sda_oe;
  logic [9:0] afe_local_raw = 10'h065;
  logic [13:0] afe_rem1_raw = 14'h0331;
  logic [13:0] afe_rem2_raw = 14'h0331;
  logic [3:0] afe_rem1_flt = 4'h4;
  logic [3:0] afe_rem2_flt = 4'h0;
  logic lvl_a;
  logic lvl_b;
  logic [7:0] rd_val;
  int err_total = 0;
  int samples_checked = 0;
  // open-drain wire with pull-up
  wire smb_sda_in = !(pull_low || (smb_sda_oe && !smb_sda_o));

  always #20 sys_clk = !sys_clk;

  // short counts keep the run small; bytes of zeros stay under the timeout
  dts_top #(.SLAVE_ADDR(SA), .TIMEOUT_CYCLES(4000), .ZONE_CYCLES(50)) dts_top_i (
    .sys_clk, .rst, .smb_clk, .smb_sda_in, .smb_sda_o, .smb_sda_oe,
    .afe_local_raw, .afe_rem1_raw, .afe_rem2_raw, .afe_rem1_flt, .afe_rem2_flt,
    .afe_run_r(), .afe_zone_r(), .afe_model_r(), .afe_comp_r(), .afe_filter_r()
  );

  dts_host #(.ADDR(SA)) dts_host_i (.smb_clk, .pull_low, .sda(smb_sda_in));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdc(input logic up, input logic [7:0] p, input logic [7:0] exp);
    dts_host_i.rd(up, p, rd_val);
    check({7'h00, dts_host_i.naks}, 8'h00);
    check(rd_val, exp);
  endtask

  task automatic wrc(input logic [7:0] p, input logic [7:0] d);
    dts_host_i.wr(p, d);
    check({7'h00, dts_host_i.naks}, 8'h00);
  endtask

  task automatic give_verdict();
    $display("Compared %0d values, %0d mismatches", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (90000) @(posedge sys_clk);
    err_total++;
    give_verdict();
  end

  // local 25.25 C, remote 25.53125 C, remote 1 faulted to ground
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    rdc(1'b0, 8'h00, 8'h19);
    rdc(1'b1, 8'h10, 8'h40);
    rdc(1'b0, 8'h00, 8'h40);
    rdc(1'b1, 8'h12, 8'h19);
    rdc(1'b1, 8'h13, 8'h88);
    rdc(1'b1, 8'h01, 8'h80);
    rdc(1'b1, 8'h02, 8'h82);
    rdc(1'b1, 8'h03, 8'h00);
    wrc(8'h06, 8'h01);
    rdc(1'b1, 8'h13, 8'h80);
    dts_host_i.probe(SA ^ 7'h01);
    check({7'h00, dts_host_i.naks}, 8'h01);
    wrc(8'h03, 8'h40);
    wrc(8'h03, 8'h42);
    wrc(8'h0F, 8'h00);
    rdc(1'b1, 8'h01, 8'hFF);
    rdc(1'b1, 8'h02, 8'h02);
    dts_host_i.stall(lvl_a, lvl_b);
    check({7'h00, lvl_a}, 8'h00);
    check({7'h00, lvl_b}, 8'h01);
    rdc(1'b1, 8'h03, 8'h42);
    give_verdict();
  end
endmodule

/* hw/dts_link_rx.sv */
`timescale 1ns/1ps
module dts_link_rx (
  input wire logic smb_clk,
  input wire logic rst,
  input wire logic sda_in,
  output logic [7:0] rx_byte_r,
  output logic bit_tgl_r
);
  // data is valid at the rising clock edge, so sample it in the clock's own domain;
  // the byte stays still until the next rising edge, and the other side reads it after the falling edge before that
  always_ff @(posedge smb_clk or posedge rst) begin
    if (rst) begin
      rx_byte_r <= 8'h00;
      bit_tgl_r <= 1'b0;
    end else begin
      rx_byte_r <= {rx_byte_r[6:0], sda_in};
      bit_tgl_r <= ~bit_tgl_r;
    end
  end
endmodule

/* hw/dts_map.svh */
`ifndef DTS_MAP_SVH
`define DTS_MAP_SVH

// clock and timing figures
`define DTS_SYS_CLK_KHZ 25000
`define DTS_TOUT_MIN_MS 25
`define DTS_TOUT_MAX_MS 35
`define DTS_PASS_TENTH_MS 675
`define DTS_ZONES 3
`define DTS_CNT_W 20

// selectable slave addresses, one per variant
`define DTS_ADDR_V0 7'h2B
`define DTS_ADDR_V1 7'h19
`define DTS_ADDR_V2 7'h2A

// register pointer values
`define DTS_REG_LOC_HI 8'h00
`define DTS_REG_R1_HI 8'h01
`define DTS_REG_STATUS 8'h02
`define DTS_REG_SETUP 8'h03
`define DTS_REG_FILTER 8'h06
`define DTS_REG_COMP 8'h07
`define DTS_REG_ONESHOT 8'h0F
`define DTS_REG_LOC_LO 8'h10
`define DTS_REG_R1_LO 8'h11
`define DTS_REG_R2_HI 8'h12
`define DTS_REG_R2_LO 8'h13
`define DTS_REG_MODEL 8'h30
`define DTS_REG_MFR_ID 8'hFE
`define DTS_REG_REV_ID 8'hFF

// status bits
`define DTS_ST_BUSY 7
`define DTS_ST_R1_MISS 1
`define DTS_ST_R2_MISS 0

// setup fields
`define DTS_SU_SHDN 6
`define DTS_SU_RATE_HI 5
`define DTS_SU_RATE_LO 4
`define DTS_SU_R2_UNS 2
`define DTS_SU_R1_UNS 1

// per-remote bit in filter, model and compensation registers
`define DTS_CH_R1 0
`define DTS_CH_R2 1

// reset values
`define DTS_SETUP_RST 8'h00
`define DTS_FILTER_RST 2'h3
`define DTS_MODEL_RST 2'h1
`define DTS_COMP_RST 2'h1
`define DTS_PTR_RST 8'h00
`define DTS_RESULT_RST 16'h0000

// idle zone slots inserted after a pass, per rate code
`define DTS_GAP_R0 8'h00
`define DTS_GAP_R1 8'h04
`define DTS_GAP_R2 8'h0C
`define DTS_GAP_R3 8'h2A

// fault words and formatting limits
`define DTS_FAULT_SIGNED 16'h8000
`define DTS_FAULT_UNS 16'hFFE0
`define DTS_S13_MIN 14'sh3000
`define DTS_S13_MAX 14'sh0FFF
`define DTS_FLT_CATHODE 1

// byte framing and zone codes
`define DTS_LAST_BIT 3'h7
`define DTS_ZONE_LOC 2'h0
`define DTS_ZONE_R1 2'h1
`define DTS_ZONE_R2 2'h2

`endif

/* hw/dts_pkg.sv */
package dts_pkg;

  typedef enum logic [3:0] {
    DTS_SMB_IDLE,
    DTS_SMB_ADDR,
    DTS_SMB_ADDR_ACK,
    DTS_SMB_PTR,
    DTS_SMB_PTR_ACK,
    DTS_SMB_WDATA,
    DTS_SMB_WDATA_ACK,
    DTS_SMB_RDATA,
    DTS_SMB_RDATA_ACK,
    DTS_SMB_IGNORE
  } dts_smb_state_t;

  typedef enum logic [1:0] {
    DTS_SEQ_IDLE,
    DTS_SEQ_CONV,
    DTS_SEQ_GAP
  } dts_seq_state_t;

endpackage

/* hw/dts_sync2.sv */
`timescale 1ns/1ps
module dts_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // two stages; the first is read by the second only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

/* hw/dts_top.sv */
`timescale 1ns/1ps
`include "dts_map.svh"

module dts_top #(
  parameter logic [6:0] SLAVE_ADDR = `DTS_ADDR_V0,
  parameter logic [7:0] MFR_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] REV_ID = 8'h01, // arbitrary value
  parameter int unsigned TIMEOUT_CYCLES =
    ((`DTS_TOUT_MIN_MS + `DTS_TOUT_MAX_MS) / 2) * `DTS_SYS_CLK_KHZ,
  parameter int unsigned ZONE_CYCLES =
    (`DTS_PASS_TENTH_MS * `DTS_SYS_CLK_KHZ) / (10 * `DTS_ZONES)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic smb_clk,
  input wire logic smb_sda_in,
  output logic smb_sda_o,
  output logic smb_sda_oe,
  input wire logic [9:0] afe_local_raw,
  input wire logic [13:0] afe_rem1_raw,
  input wire logic [13:0] afe_rem2_raw,
  input wire logic [3:0] afe_rem1_flt,
  input wire logic [3:0] afe_rem2_flt,
  output logic afe_run_r,
  output logic [1:0] afe_zone_r,
  output logic [1:0] afe_model_r,
  output logic [1:0] afe_comp_r,
  output logic [1:0] afe_filter_r
);
  localparam logic [`DTS_CNT_W-1:0] TOUT_LAST = (`DTS_CNT_W)'(TIMEOUT_CYCLES - 1);
  localparam logic [`DTS_CNT_W-1:0] ZONE_LAST = (`DTS_CNT_W)'(ZONE_CYCLES - 1);

  // remote word: left justified, filter off drops the two finest bits
  function automatic logic [15:0] fmt_remote(
    input logic signed [13:0] raw,
    input logic filt,
    input logic uns,
    input logic flt
  );
    logic [12:0] v;
    v = 13'h0000;
    if (uns) begin
      v = raw[13] ? 13'h0000 : raw[12:0];
    end else if (raw < `DTS_S13_MIN) begin
      v = 13'h1000;
    end else if (raw > `DTS_S13_MAX) begin
      v = 13'h0FFF;
    end else begin
      v = raw[12:0];
    end
    if (!filt) begin
      v[1:0] = 2'h0;
    end
    if (flt) begin
      fmt_remote = uns ? `DTS_FAULT_UNS : `DTS_FAULT_SIGNED;
    end else begin
      fmt_remote = {v, 3'h0};
    end
  endfunction

  // idle slots after a pass, by rate code
  function automatic logic [7:0] gap_slots(input logic [1:0] rate);
    case (rate)
      2'h0: gap_slots = `DTS_GAP_R0;
      2'h1: gap_slots = `DTS_GAP_R1;
      2'h2: gap_slots = `DTS_GAP_R2;
      default: gap_slots = `DTS_GAP_R3;
    endcase
  endfunction

  // fault present, ignoring the cathode short while compensation is on
  function automatic logic diode_fault(input logic [3:0] flt, input logic comp);
    logic [3:0] m;
    m = flt;
    if (comp) begin
      m[`DTS_FLT_CATHODE] = 1'b0;
    end
    diode_fault = |m;
  endfunction

  logic [7:0] rx_byte;
  logic bit_tgl;
  logic scl_s;
  logic sda_s;
  logic bit_tgl_s;
  logic scl_q;
  logic sda_q;
  logic bit_tgl_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic bit_evt;
  logic [9:0] loc_raw_s;
  logic [13:0] r1_raw_s;
  logic [13:0] r2_raw_s;
  logic [3:0] r1_flt_s;
  logic [3:0] r2_flt_s;

  dts_pkg::dts_smb_state_t smb_st_r;
  logic [2:0] bitcnt_r;
  logic rx_done_r;
  logic rw_r;
  logic nack_r;
  logic [7:0] ptr_r;
  logic [7:0] tx_r;
  logic reg_wr_r;
  logic [7:0] reg_wdata_r;
  logic [`DTS_CNT_W-1:0] tout_cnt_r;
  logic tout_hit;

  logic [7:0] setup_r;
  logic [1:0] filter_r;
  logic [1:0] model_r;
  logic [1:0] comp_r;
  logic oneshot_r;

  dts_pkg::dts_seq_state_t seq_st_r;
  logic [`DTS_CNT_W-1:0] cyc_r;
  logic [7:0] slot_r;
  logic os_take_r;
  logic cap_r;
  logic [1:0] cap_zone_r;

  logic [15:0] loc_r;
  logic [15:0] r1_r;
  logic [15:0] r2_r;
  logic miss1_r;
  logic miss2_r;
  logic [7:0] rd_mux;
  logic [7:0] status;

  // bits are sampled on the link's own clock
  dts_link_rx u_link (
    .smb_clk(smb_clk),
    .rst(rst),
    .sda_in(smb_sda_in),
    .rx_byte_r(rx_byte),
    .bit_tgl_r(bit_tgl)
  );

  dts_sync2 #(.W(3)) u_sync_bus (
    .clk(sys_clk),
    .rst(rst),
    .d({smb_clk, smb_sda_in, bit_tgl}),
    .q({scl_s, sda_s, bit_tgl_s})
  );

  // analog outputs are assumed steady around the end of a zone
  dts_sync2 #(.W(46)) u_sync_afe (
    .clk(sys_clk),
    .rst(rst),
    .d({afe_local_raw, afe_rem1_raw, afe_rem2_raw, afe_rem1_flt, afe_rem2_flt}),
    .q({loc_raw_s, r1_raw_s, r2_raw_s, r1_flt_s, r2_flt_s})
  );

  // previous samples for edge and condition detection
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_tgl_q <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      bit_tgl_q <= bit_tgl_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
  assign bus_stop = scl_s & scl_q & ~sda_q & sda_s;
  assign bit_evt = bit_tgl_s ^ bit_tgl_q;

  // either line low too long counts toward the bus timeout
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tout_cnt_r <= '0;
    end else if (scl_s && sda_s) begin
      tout_cnt_r <= '0;
    end else if (!tout_hit) begin
      tout_cnt_r <= tout_cnt_r + 1'b1;
    end
  end

  assign tout_hit = (tout_cnt_r == TOUT_LAST);

  // slave protocol engine; the clock line is never driven, so no stretching
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      smb_st_r <= dts_pkg::DTS_SMB_IDLE;
      bitcnt_r <= 3'h0;
      rx_done_r <= 1'b0;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      ptr_r <= `DTS_PTR_RST;
      tx_r <= 8'h00;
      reg_wr_r <= 1'b0;
      reg_wdata_r <= 8'h00;
      smb_sda_oe <= 1'b0;
    end else begin
      reg_wr_r <= 1'b0;
      if (tout_hit) begin
        smb_st_r <= dts_pkg::DTS_SMB_IDLE;
        smb_sda_oe <= 1'b0;
      end else if (bus_start) begin
        smb_st_r <= dts_pkg::DTS_SMB_ADDR;
        bitcnt_r <= 3'h0;
        rx_done_r <= 1'b0;
        smb_sda_oe <= 1'b0;
      end else if (bus_stop) begin
        smb_st_r <= dts_pkg::DTS_SMB_IDLE;
        smb_sda_oe <= 1'b0;
      end else begin
        case (smb_st_r)
          dts_pkg::DTS_SMB_ADDR, dts_pkg::DTS_SMB_PTR, dts_pkg::DTS_SMB_WDATA: begin
            if (bit_evt) begin
              bitcnt_r <= bitcnt_r + 1'b1;
              if (bitcnt_r == `DTS_LAST_BIT) begin
                rx_done_r <= 1'b1;
              end
            end
            if (scl_fall && rx_done_r) begin
              rx_done_r <= 1'b0;
              bitcnt_r <= 3'h0;
              if (smb_st_r == dts_pkg::DTS_SMB_ADDR) begin
                if (rx_byte[7:1] == SLAVE_ADDR) begin
                  rw_r <= rx_byte[0];
                  smb_sda_oe <= 1'b1;
                  smb_st_r <= dts_pkg::DTS_SMB_ADDR_ACK;
                end else begin
                  smb_st_r <= dts_pkg::DTS_SMB_IGNORE;
                end
              end else if (smb_st_r == dts_pkg::DTS_SMB_PTR) begin
                ptr_r <= rx_byte;
                smb_sda_oe <= 1'b1;
                smb_st_r <= dts_pkg::DTS_SMB_PTR_ACK;
              end else begin
                reg_wdata_r <= rx_byte;
                reg_wr_r <= 1'b1;
                smb_sda_oe <= 1'b1;
                smb_st_r <= dts_pkg::DTS_SMB_WDATA_ACK;
              end
            end
          end
          dts_pkg::DTS_SMB_ADDR_ACK: begin
            if (scl_fall) begin
              if (rw_r) begin
                tx_r <= rd_mux;
                smb_sda_oe <= ~rd_mux[7];
                bitcnt_r <= 3'h0;
                smb_st_r <= dts_pkg::DTS_SMB_RDATA;
              end else begin
                smb_sda_oe <= 1'b0;
                smb_st_r <= dts_pkg::DTS_SMB_PTR;
              end
            end
          end
          dts_pkg::DTS_SMB_PTR_ACK: begin
            if (scl_fall) begin
              smb_sda_oe <= 1'b0;
              smb_st_r <= dts_pkg::DTS_SMB_WDATA;
            end
          end
          dts_pkg::DTS_SMB_WDATA_ACK: begin
            if (scl_fall) begin
              smb_sda_oe <= 1'b0;
              smb_st_r <= dts_pkg::DTS_SMB_IGNORE;
            end
          end
          dts_pkg::DTS_SMB_RDATA: begin
            if (scl_fall) begin
              if (bitcnt_r == `DTS_LAST_BIT) begin
                smb_sda_oe <= 1'b0;
                smb_st_r <= dts_pkg::DTS_SMB_RDATA_ACK;
              end else begin
                tx_r <= {tx_r[6:0], 1'b0};
                smb_sda_oe <= ~tx_r[6];
                bitcnt_r <= bitcnt_r + 1'b1;
              end
            end
          end
          dts_pkg::DTS_SMB_RDATA_ACK: begin
            if (scl_rise) begin
              nack_r <= sda_s;
            end
            if (scl_fall) begin
              if (nack_r) begin
                smb_st_r <= dts_pkg::DTS_SMB_IGNORE;
              end else begin
                // no auto-increment: the same location is sent again
                tx_r <= rd_mux;
                smb_sda_oe <= ~rd_mux[7];
                bitcnt_r <= 3'h0;
                smb_st_r <= dts_pkg::DTS_SMB_RDATA;
              end
            end
          end
          default: begin
            smb_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      smb_sda_o <= 1'b0;
    end else begin
      smb_sda_o <= 1'b0;
    end
  end

  // writable control registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      setup_r <= `DTS_SETUP_RST;
      filter_r <= `DTS_FILTER_RST;
      model_r <= `DTS_MODEL_RST;
      comp_r <= `DTS_COMP_RST;
    end else if (reg_wr_r) begin
      case (ptr_r)
        `DTS_REG_SETUP: setup_r <= reg_wdata_r;
        `DTS_REG_FILTER: filter_r <= reg_wdata_r[1:0];
        `DTS_REG_MODEL: model_r <= reg_wdata_r[1:0];
        `DTS_REG_COMP: comp_r <= reg_wdata_r[1:0];
        default: setup_r <= setup_r;
      endcase
    end
  end

  // one-shot request; a new write wins over the sequencer taking the old one
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oneshot_r <= 1'b0;
    end else if (reg_wr_r && ptr_r == `DTS_REG_ONESHOT) begin
      oneshot_r <= 1'b1;
    end else if (os_take_r) begin
      oneshot_r <= 1'b0;
    end
  end

  // conversion sequencer: three zone slots per pass, then rate gap
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      seq_st_r <= dts_pkg::DTS_SEQ_IDLE;
      cyc_r <= '0;
      slot_r <= 8'h00;
      afe_zone_r <= `DTS_ZONE_LOC;
      os_take_r <= 1'b0;
      cap_r <= 1'b0;
      cap_zone_r <= `DTS_ZONE_LOC;
    end else begin
      os_take_r <= 1'b0;
      cap_r <= 1'b0;
      case (seq_st_r)
        dts_pkg::DTS_SEQ_IDLE: begin
          if (!setup_r[`DTS_SU_SHDN] || oneshot_r) begin
            os_take_r <= oneshot_r;
            cyc_r <= '0;
            afe_zone_r <= `DTS_ZONE_LOC;
            seq_st_r <= dts_pkg::DTS_SEQ_CONV;
          end
        end
        dts_pkg::DTS_SEQ_CONV: begin
          if (cyc_r == ZONE_LAST) begin
            cyc_r <= '0;
            cap_r <= 1'b1;
            cap_zone_r <= afe_zone_r;
            if (afe_zone_r == `DTS_ZONE_R2) begin
              afe_zone_r <= `DTS_ZONE_LOC;
              slot_r <= 8'h00;
              if (setup_r[`DTS_SU_SHDN]) begin
                seq_st_r <= dts_pkg::DTS_SEQ_IDLE;
              end else if (gap_slots(setup_r[`DTS_SU_RATE_HI:`DTS_SU_RATE_LO]) != 8'h00) begin
                seq_st_r <= dts_pkg::DTS_SEQ_GAP;
              end
            end else begin
              afe_zone_r <= afe_zone_r + 1'b1;
            end
          end else begin
            cyc_r <= cyc_r + 1'b1;
          end
        end
        dts_pkg::DTS_SEQ_GAP: begin
          if (setup_r[`DTS_SU_SHDN]) begin
            seq_st_r <= dts_pkg::DTS_SEQ_IDLE;
          end else if (cyc_r == ZONE_LAST) begin
            cyc_r <= '0;
            slot_r <= slot_r + 1'b1;
            if (slot_r + 8'h01 >= gap_slots(setup_r[`DTS_SU_RATE_HI:`DTS_SU_RATE_LO])) begin
              seq_st_r <= dts_pkg::DTS_SEQ_CONV;
            end
          end else begin
            cyc_r <= cyc_r + 1'b1;
          end
        end
        default: begin
          seq_st_r <= dts_pkg::DTS_SEQ_IDLE;
        end
      endcase
    end
  end

  // settings presented to the front end for every conversion
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      afe_run_r <= 1'b0;
      afe_model_r <= `DTS_MODEL_RST;
      afe_comp_r <= `DTS_COMP_RST;
      afe_filter_r <= `DTS_FILTER_RST;
    end else begin
      afe_run_r <= (seq_st_r == dts_pkg::DTS_SEQ_CONV);
      afe_model_r <= model_r;
      afe_comp_r <= comp_r;
      afe_filter_r <= filter_r;
    end
  end

  // results replace whole words at zone end, so hi and lo always match
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      loc_r <= `DTS_RESULT_RST;
      r1_r <= `DTS_RESULT_RST;
      r2_r <= `DTS_RESULT_RST;
      miss1_r <= 1'b0;
      miss2_r <= 1'b0;
    end else if (cap_r) begin
      case (cap_zone_r)
        `DTS_ZONE_LOC: loc_r <= {loc_raw_s, 6'h00};
        `DTS_ZONE_R1: begin
          r1_r <= fmt_remote(r1_raw_s, filter_r[`DTS_CH_R1], setup_r[`DTS_SU_R1_UNS],
                             diode_fault(r1_flt_s, comp_r[`DTS_CH_R1]));
          miss1_r <= diode_fault(r1_flt_s, comp_r[`DTS_CH_R1]);
        end
        default: begin
          r2_r <= fmt_remote(r2_raw_s, filter_r[`DTS_CH_R2], setup_r[`DTS_SU_R2_UNS],
                             diode_fault(r2_flt_s, comp_r[`DTS_CH_R2]));
          miss2_r <= diode_fault(r2_flt_s, comp_r[`DTS_CH_R2]);
        end
      endcase
    end
  end

  // status view: busy comes straight from the sequencer state
  always_comb begin
    status = 8'h00;
    status[`DTS_ST_BUSY] = (seq_st_r == dts_pkg::DTS_SEQ_CONV);
    status[`DTS_ST_R1_MISS] = miss1_r;
    status[`DTS_ST_R2_MISS] = miss2_r;
  end

  // read selection; results are stored copies, never work in progress
  always_comb begin
    case (ptr_r)
      `DTS_REG_LOC_HI: rd_mux = loc_r[15:8];
      `DTS_REG_LOC_LO: rd_mux = loc_r[7:0];
      `DTS_REG_R1_HI: rd_mux = r1_r[15:8];
      `DTS_REG_R1_LO: rd_mux = r1_r[7:0];
      `DTS_REG_R2_HI: rd_mux = r2_r[15:8];
      `DTS_REG_R2_LO: rd_mux = r2_r[7:0];
      `DTS_REG_STATUS: rd_mux = status;
      `DTS_REG_SETUP: rd_mux = setup_r;
      `DTS_REG_FILTER: rd_mux = {6'h00, filter_r};
      `DTS_REG_MODEL: rd_mux = {6'h00, model_r};
      `DTS_REG_COMP: rd_mux = {6'h00, comp_r};
      `DTS_REG_MFR_ID: rd_mux = MFR_ID;
      `DTS_REG_REV_ID: rd_mux = REV_ID;
      default: rd_mux = 8'h00;
    endcase
  end
endmodule
